/* tcz_pkg.sv */
// Package: register map, field layout and types of the timer core channel zero
package tcz_pkg;

  // ==========================================================
  // Register offsets (byte wide, printed offsets)
  localparam logic [7:0] ADDR_CNT_LOW = 8'he2;
  localparam logic [7:0] ADDR_CNT_HIGH = 8'he3;
  localparam logic [7:0] ADDR_CTL = 8'he4;
  localparam logic [7:0] ADDR_CH0_CTL = 8'he5;
  localparam logic [7:0] ADDR_CH0_VAL_LOW = 8'hda;
  localparam logic [7:0] ADDR_CH0_VAL_HIGH = 8'hdb;

  // ==========================================================
  // Field positions
  localparam int CTL_CH2_FLAG = 7;
  localparam int CTL_CH1_FLAG = 6;
  localparam int CTL_CH0_FLAG = 5;
  localparam int CTL_WRAP_FLAG = 4;
  localparam int CTL_DIV_LSB = 2;
  localparam int CTL_MODE_LSB = 0;
  localparam int CC_SRC_BIT = 7;
  localparam int CC_IRQ_MASK_BIT = 6;
  localparam int CC_ACT_LSB = 3;
  localparam int CC_CMP_BIT = 2;
  localparam int CC_EDGE_LSB = 0;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CH0_CTL_RESET = 8'h40;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;

  // Prescaler terminal counts (divide minus one)
  localparam logic [6:0] DIV8_LAST = 7'h07;
  localparam logic [6:0] DIV32_LAST = 7'h1f;
  localparam logic [6:0] DIV128_LAST = 7'h7f;

  typedef enum logic [1:0] {
    MODE_STOP = 2'h0,
    MODE_FREE = 2'h1,
    MODE_MOD = 2'h2,
    MODE_UPDN = 2'h3
  } tcz_mode_t;

  typedef enum logic [1:0] {
    DIV_1 = 2'h0,
    DIV_8 = 2'h1,
    DIV_32 = 2'h2,
    DIV_128 = 2'h3
  } tcz_div_t;

  typedef enum logic [2:0] {
    ACT_SET = 3'h0,
    ACT_CLR = 3'h1,
    ACT_TGL = 3'h2,
    ACT_SET_UP = 3'h3,
    ACT_CLR_UP = 3'h4
  } tcz_act_t;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tcz_bus_t;

  // Event outputs toward neighbouring logic
  typedef struct packed {
    logic terminal;
    logic compare;
    logic capture;
  } tcz_evt_t;

endpackage : tcz_pkg

/* tcz_timer.sv */
// Timer core with 16-bit counter, prescaler and channel 0 capture/compare unit
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps

// Summary of operation
// - Reading counter low byte snapshots upper counter byte for later high read.
// - Any write to counter low byte clears whole counter to zero.
// - Flags for channels 2,1,0 in control bits 7,6,5; write zero clears.
// - Wrap flag bit 4 sets at terminal count or at zero turnaround.
// - Prescale field 3:2 divides ticks by 1, 8, 32 or 128.
// - Writing prescale field never resets the prescaler counter.
// - Mode 00 stops the counter, holding its value.
// - Mode 01 counts zero to 0xffff then wraps.
// - Mode 10 counts zero to channel 0 value then restarts.
// - Mode 11 counts up to channel 0 value, down to zero, repeats.
// - Source bit 7 picks capture pin (0) or radio events (1).
// - Channel 0 control bit 6 is interrupt mask, reset value one.
// - Output actions 000, 001, 010 set, clear, toggle on match.
// - Action 011 sets on up match, clears on down match or, outside mode 11, at zero.
// - Action 100 clears on up match, sets on down match or, outside mode 11, at zero.
// - Match when counter equals channel 0 value; field 5:3 picks response.
// - Channel 0 control bit 2 selects capture (0) or compare (1).
// - Edge field: none, rising, falling, or both edges capture.
// - Flags set regardless of masks; processor flag needs a set mask.
// - Up/down compare mode sets channel 0 and wrap flags at zero turn.
module tcz_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire tcz_pkg::tcz_bus_t bus,
  output logic [7:0] rdata,
  // Tick enable from the system clock divider
  input wire logic tick_en,
  // Capture sources
  input wire logic capture_pin,
  input wire logic radio_event,
  // Channel 1 and 2 events from neighbouring channels, and the wrap interrupt mask
  input wire logic ch1_event,
  input wire logic ch2_event,
  input wire logic ovf_irq_mask,
  // Results
  output logic ch0_out,
  output logic processor_timer_irq_flag,
  output tcz_pkg::tcz_evt_t evt,
  output logic [15:0] terminal_value
);

  // ==========================================================
  // Helpers
  function automatic logic [6:0] div_last(input logic [1:0] sel);
    unique case (tcz_pkg::tcz_div_t'(sel))
      tcz_pkg::DIV_1: div_last = 7'h00;
      tcz_pkg::DIV_8: div_last = tcz_pkg::DIV8_LAST;
      tcz_pkg::DIV_32: div_last = tcz_pkg::DIV32_LAST;
      tcz_pkg::DIV_128: div_last = tcz_pkg::DIV128_LAST;
    endcase
  endfunction : div_last

  // ==========================================================
  // State
  logic [15:0] cnt_r, cnt_nxt;
  logic [7:0] snap_r, snap_nxt;
  logic [7:0] ctl_r, ctl_nxt;
  logic [7:0] cc_ctl_r, cc_ctl_nxt;
  logic [15:0] cc_val_r, cc_val_nxt;
  logic [6:0] pre_r, pre_nxt;
  logic down_r, down_nxt;
  logic src_d_r, src_d_nxt;
  logic out_r, out_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic irq_r, irq_nxt;
  tcz_pkg::tcz_evt_t evt_r, evt_nxt;

  logic [1:0] mode;
  logic [1:0] div_sel;
  logic [2:0] act;
  logic [1:0] edge_sel;
  logic cmp_mode;
  logic step;
  logic match;
  logic at_top;
  logic wrap_evt;
  logic turn_zero;
  logic src;
  logic cap_evt;
  logic match_evt;
  logic ch0_evt;
  logic wr_ctl;

  assign mode = ctl_r[tcz_pkg::CTL_MODE_LSB +: 2];
  assign div_sel = ctl_r[tcz_pkg::CTL_DIV_LSB +: 2];
  assign act = cc_ctl_r[tcz_pkg::CC_ACT_LSB +: 3];
  assign edge_sel = cc_ctl_r[tcz_pkg::CC_EDGE_LSB +: 2];
  assign cmp_mode = cc_ctl_r[tcz_pkg::CC_CMP_BIT];
  assign wr_ctl = bus.wr && (bus.addr == tcz_pkg::ADDR_CTL);

  // ==========================================================
  // Prescaler and counter
  always_comb begin
    pre_nxt = pre_r;
    step = 1'b0;
    if (tick_en) begin
      // Field change applies at once; running count is compared with the new terminal count
      if (pre_r >= div_last(div_sel)) begin
        pre_nxt = 7'h00;
        step = 1'b1;
      end else begin
        pre_nxt = pre_r + 7'h01;
      end
    end
  end

  always_comb begin
    cnt_nxt = cnt_r;
    down_nxt = down_r;
    wrap_evt = 1'b0;
    turn_zero = 1'b0;
    at_top = 1'b0;
    if (step) begin
      unique case (tcz_pkg::tcz_mode_t'(mode))
        tcz_pkg::MODE_STOP: cnt_nxt = cnt_r;
        tcz_pkg::MODE_FREE: begin
          cnt_nxt = cnt_r + 16'h0001;
          wrap_evt = (cnt_r == tcz_pkg::CNT_MAX);
          at_top = wrap_evt;
        end
        tcz_pkg::MODE_MOD: begin
          at_top = (cnt_r >= cc_val_r);
          wrap_evt = at_top;
          cnt_nxt = at_top ? tcz_pkg::CNT_ZERO : cnt_r + 16'h0001;
        end
        // Up to value, then down to zero
        tcz_pkg::MODE_UPDN: begin
          if (!down_r) begin
            if (cnt_r >= cc_val_r && cnt_r != tcz_pkg::CNT_ZERO) begin
              down_nxt = 1'b1;
              cnt_nxt = cnt_r - 16'h0001;
            end else begin
              cnt_nxt = (cc_val_r == tcz_pkg::CNT_ZERO) ? cnt_r : cnt_r + 16'h0001;
            end
          end else if (cnt_r == 16'h0001 || cnt_r == tcz_pkg::CNT_ZERO) begin
            cnt_nxt = tcz_pkg::CNT_ZERO;
            down_nxt = 1'b0;
            turn_zero = 1'b1;
            wrap_evt = 1'b1;
          end else begin
            cnt_nxt = cnt_r - 16'h0001;
          end
        end
      endcase
    end
    // Any write to low byte clears counter
    if (bus.wr && bus.addr == tcz_pkg::ADDR_CNT_LOW) begin
      cnt_nxt = tcz_pkg::CNT_ZERO;
      down_nxt = 1'b0;
    end
    if (wr_ctl && bus.wdata[tcz_pkg::CTL_MODE_LSB +: 2] != tcz_pkg::MODE_UPDN) begin
      down_nxt = 1'b0;
    end
  end

  // ==========================================================
  // Channel 0 capture and compare
  always_comb begin
    src = cc_ctl_r[tcz_pkg::CC_SRC_BIT] ? radio_event : capture_pin;
    src_d_nxt = src;
    // Capture only when bit 2 is clear
    cap_evt = !cmp_mode &&
              ((edge_sel[0] && src && !src_d_r) || (edge_sel[1] && !src && src_d_r));
    // Match on equal value, checked at each step on the count being left
    match = (cnt_r == cc_val_r);
    match_evt = cmp_mode && step && match && mode != tcz_pkg::MODE_STOP;
    // In up/down compare, channel 0 event is the zero turnaround
    ch0_evt = cap_evt ||
              (mode == tcz_pkg::MODE_UPDN ? (cmp_mode && turn_zero) : match_evt);
    cc_val_nxt = cc_val_r;
    if (cap_evt) begin
      cc_val_nxt = cnt_r;
    end else if (bus.wr && bus.addr == tcz_pkg::ADDR_CH0_VAL_LOW) begin
      cc_val_nxt[7:0] = bus.wdata;
    end else if (bus.wr && bus.addr == tcz_pkg::ADDR_CH0_VAL_HIGH) begin
      cc_val_nxt[15:8] = bus.wdata;
    end
  end

  always_comb begin
    out_nxt = out_r;
    if (cmp_mode && step && mode != tcz_pkg::MODE_STOP) begin
      // Set up, clear down or at zero outside up/down mode
      // Clear up, set down or at zero outside up/down mode
      if (match) begin
        unique case (act)
          tcz_pkg::ACT_SET: out_nxt = 1'b1;
          tcz_pkg::ACT_CLR: out_nxt = 1'b0;
          tcz_pkg::ACT_TGL: out_nxt = !out_r;
          tcz_pkg::ACT_SET_UP: out_nxt = !down_r;
          tcz_pkg::ACT_CLR_UP: out_nxt = down_r;
          default: out_nxt = out_r;
        endcase
      end else if (cnt_r == tcz_pkg::CNT_ZERO && mode != tcz_pkg::MODE_UPDN) begin
        if (act == tcz_pkg::ACT_SET_UP) begin
          out_nxt = 1'b0;
        end else if (act == tcz_pkg::ACT_CLR_UP) begin
          out_nxt = 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Registers and flags
  always_comb begin
    ctl_nxt = ctl_r;
    cc_ctl_nxt = cc_ctl_r;
    snap_nxt = snap_r;
    if (wr_ctl) begin
      // Flags clear only on written zero
      ctl_nxt[tcz_pkg::CTL_CH2_FLAG:tcz_pkg::CTL_WRAP_FLAG] =
        ctl_r[tcz_pkg::CTL_CH2_FLAG:tcz_pkg::CTL_WRAP_FLAG] &
        bus.wdata[tcz_pkg::CTL_CH2_FLAG:tcz_pkg::CTL_WRAP_FLAG];
      ctl_nxt[tcz_pkg::CTL_DIV_LSB +: 2] = bus.wdata[tcz_pkg::CTL_DIV_LSB +: 2];
      ctl_nxt[tcz_pkg::CTL_MODE_LSB +: 2] = bus.wdata[tcz_pkg::CTL_MODE_LSB +: 2];
    end
    // Events set flags without regard to masks; set beats clear
    if (ch2_event) ctl_nxt[tcz_pkg::CTL_CH2_FLAG] = 1'b1;
    if (ch1_event) ctl_nxt[tcz_pkg::CTL_CH1_FLAG] = 1'b1;
    if (ch0_evt) ctl_nxt[tcz_pkg::CTL_CH0_FLAG] = 1'b1;
    if (wrap_evt) ctl_nxt[tcz_pkg::CTL_WRAP_FLAG] = 1'b1;
    // Mask bit is plain storage, reset to one
    if (bus.wr && bus.addr == tcz_pkg::ADDR_CH0_CTL) cc_ctl_nxt = bus.wdata;
    // Snapshot upper byte on low read
    if (bus.rd && bus.addr == tcz_pkg::ADDR_CNT_LOW) snap_nxt = cnt_r[15:8];
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        tcz_pkg::ADDR_CNT_LOW: rdata_nxt = cnt_r[7:0];
        tcz_pkg::ADDR_CNT_HIGH: rdata_nxt = snap_r;
        tcz_pkg::ADDR_CTL: rdata_nxt = ctl_r;
        tcz_pkg::ADDR_CH0_CTL: rdata_nxt = cc_ctl_r;
        tcz_pkg::ADDR_CH0_VAL_LOW: rdata_nxt = cc_val_r[7:0];
        tcz_pkg::ADDR_CH0_VAL_HIGH: rdata_nxt = cc_val_r[15:8];
        default: rdata_nxt = 8'h00;
      endcase
    end
    // Processor flag only through a set mask
    irq_nxt = (ch0_evt && cc_ctl_r[tcz_pkg::CC_IRQ_MASK_BIT]) ||
              (wrap_evt && ovf_irq_mask);
    evt_nxt.terminal = at_top || turn_zero;
    evt_nxt.compare = match_evt;
    evt_nxt.capture = cap_evt;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= tcz_pkg::CNT_ZERO;
      snap_r <= 8'h00;
      ctl_r <= tcz_pkg::CTL_RESET;
      cc_ctl_r <= tcz_pkg::CH0_CTL_RESET;
      cc_val_r <= tcz_pkg::CNT_ZERO;
      pre_r <= 7'h00;
      down_r <= 1'b0;
      src_d_r <= 1'b0;
      out_r <= 1'b0;
      rdata_r <= 8'h00;
      irq_r <= 1'b0;
      evt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      snap_r <= snap_nxt;
      ctl_r <= ctl_nxt;
      cc_ctl_r <= cc_ctl_nxt;
      cc_val_r <= cc_val_nxt;
      pre_r <= pre_nxt;
      down_r <= down_nxt;
      src_d_r <= src_d_nxt;
      out_r <= out_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      evt_r <= evt_nxt;
    end
  end

  assign rdata = rdata_r;
  assign ch0_out = out_r;
  assign processor_timer_irq_flag = irq_r;
  assign evt = evt_r;
  assign terminal_value = cc_val_r;

endmodule : tcz_timer

/* tcz_timer_chk.sv */
// Checker: port assertions of the timer core
`timescale 1ns/1ps
module tcz_timer_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched ports
  input wire tcz_pkg::tcz_bus_t bus,
  input wire logic [7:0] rdata,
  input wire logic ovf_irq_mask,
  input wire logic processor_timer_irq_flag,
  input wire tcz_pkg::tcz_evt_t evt,
  input wire logic [15:0] terminal_value
);
  wire logic wr_cl = bus.wr && bus.addr == tcz_pkg::ADDR_CNT_LOW;
  wire logic rd_cl = bus.rd && bus.addr == tcz_pkg::ADDR_CNT_LOW;
  wire logic wr_ct = bus.wr && bus.addr == tcz_pkg::ADDR_CTL;
  wire logic rd_ct = bus.rd && bus.addr == tcz_pkg::ADDR_CTL;
  wire logic wr_cc = bus.wr && bus.addr == tcz_pkg::ADDR_CH0_CTL;
  wire logic rd_cc = bus.rd && bus.addr == tcz_pkg::ADDR_CH0_CTL;
  wire logic wr_vl = bus.wr && bus.addr == tcz_pkg::ADDR_CH0_VAL_LOW;
  wire logic wr_vh = bus.wr && bus.addr == tcz_pkg::ADDR_CH0_VAL_HIGH;
  wire logic rd_bad = bus.rd && bus.addr[7:4] != 4'he && bus.addr[7:1] != 7'h6d;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ====================================
  // Register port
  rd_idle_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data without read");
  rd_unmap_a: assert property (rd_bad |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  cnt_clear_a: assert property (wr_cl ##1 rd_cl |=> rdata == 8'h00)
    else $error("counter not cleared");
  ctl_rback_a: assert property (wr_ct ##1 rd_ct |=>
    rdata[3:0] == $past(bus.wdata[3:0], 2))
    else $error("control field lost");
  ch0_rback_a: assert property (wr_cc ##1 rd_cc |=> rdata == $past(bus.wdata, 2))
    else $error("channel control lost");
  val_low_a: assert property (wr_vl |=> evt.capture ||
    terminal_value[7:0] == $past(bus.wdata))
    else $error("value low not written");
  val_high_a: assert property (wr_vh |=> evt.capture ||
    terminal_value[15:8] == $past(bus.wdata))
    else $error("value high not written");
  // ====================================
  // Interrupt flag
  // Mask counts at the wrap edge, one cycle before both pulses show
  wrap_irq_a: assert property (evt.terminal && $past(ovf_irq_mask)
    |-> processor_timer_irq_flag)
    else $error("wrap without processor flag");
endmodule : tcz_timer_chk

bind tcz_timer tcz_timer_chk u_tcz_timer_chk (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
  .ovf_irq_mask(ovf_irq_mask), .processor_timer_irq_flag(processor_timer_irq_flag),
  .evt(evt), .terminal_value(terminal_value));

/* tcz_cpu_model.sv */
// Processor core model on the timer register port
`timescale 1ns/1ps
module tcz_cpu_model (
  // Clock
  input wire logic clk,
  // Register port
  output tcz_pkg::tcz_bus_t bus,
  input wire logic [7:0] rdata
);
  initial bus = '0;
  // One request a cycle; got is the answer to the request before
  task automatic op(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r,
      output logic [7:0] got);
    bus <= '{a, d, w, r};
    @(posedge clk);
    got = rdata;
  endtask : op
endmodule : tcz_cpu_model

/* tcz_timer_tb.sv */
// Testbench: registers, counting, compare and capture of the timer
`timescale 1ns/1ps
module tcz_timer_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic tick_en = 1'b1;
  logic capture_pin = 1'b0;
  logic radio_event = 1'b0;
  logic ch1_event = 1'b0;
  logic ch2_event = 1'b0;
  logic ovf_irq_mask = 1'b1;
  logic [7:0] rdata;
  logic ch0_out;
  logic irq;
  logic o1;
  logic [7:0] g;
  logic [7:0] a;
  logic [15:0] tval;
  tcz_pkg::tcz_bus_t bus;
  tcz_pkg::tcz_evt_t evt;
  int mismatches = 0;
  int checks_done = 0;
  int irqs = 0;
  int cmps = 0;
  int dv;
  typedef struct packed {logic [7:0] ad; logic [7:0] wd; logic w; logic [7:0] ex;} tcz_row_t;
  tcz_row_t rows [12] = '{'{8'he4, 8'h00, 1'b0, 8'h00}, '{8'he3, 8'h00, 1'b0, 8'h00},
    '{8'he5, 8'h00, 1'b0, 8'h40}, '{8'hda, 8'h00, 1'b0, 8'h00}, '{8'hdb, 8'h00, 1'b0, 8'h00},
    '{8'h10, 8'h00, 1'b0, 8'h00}, '{8'he2, 8'h5a, 1'b1, 8'h00}, '{8'he5, 8'h24, 1'b1, 8'h24},
    '{8'he4, 8'h0c, 1'b1, 8'h0c}, '{8'hda, 8'h34, 1'b1, 8'h34}, '{8'hdb, 8'h12, 1'b1, 8'h12},
    '{8'he3, 8'h77, 1'b1, 8'h00}};
  logic [7:0] ctls [5] = '{8'h01, 8'h05, 8'h09, 8'h0d, 8'h00};
  logic [2:0] acts [4] = '{3'h0, 3'h1, 3'h3, 3'h4};
  logic acx [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

  tcz_timer u_tcz_timer (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .tick_en(tick_en),
    .capture_pin(capture_pin), .radio_event(radio_event), .ch1_event(ch1_event),
    .ch2_event(ch2_event), .ovf_irq_mask(ovf_irq_mask), .ch0_out(ch0_out),
    .processor_timer_irq_flag(irq), .evt(evt), .terminal_value(tval));
  tcz_cpu_model u_tcz_cpu_model (.clk(clk), .bus(bus), .rdata(rdata));

  initial forever #20 clk = ~clk;

  // ====================================
  // Helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic nop(input int n);
    repeat (n) begin
      u_tcz_cpu_model.op(8'h00, 8'h00, 1'b0, 1'b0, g);
      if (irq === 1'b1) irqs++;
      if (evt.compare === 1'b1) cmps++;
    end
  endtask : nop
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    u_tcz_cpu_model.op(ad, d, 1'b1, 1'b0, g);
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [7:0] v);
    u_tcz_cpu_model.op(ad, 8'h00, 1'b0, 1'b1, v);
    u_tcz_cpu_model.op(8'h00, 8'h00, 1'b0, 1'b0, v);
  endtask : rd
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #3200us;
    mismatches++;
    print_verdict();
  end

  // ====================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      if (rows[i].w) wr(rows[i].ad, rows[i].wd);
      rd(rows[i].ad, g);
      chk(g, rows[i].ex);
    end
    // Snapshot must hold while the high byte moves on
    wr(8'he4, 8'h01);
    wr(8'he2, 8'h00);
    nop(16'h12ff);
    u_tcz_cpu_model.op(8'he2, 8'h00, 1'b0, 1'b1, g);
    u_tcz_cpu_model.op(8'he3, 8'h00, 1'b0, 1'b1, a);
    nop(1);
    chk(a, 8'hff);
    chk(g, 8'h12);
    nop(16'hed00);
    rd(8'he4, g);
    chk(g, 8'h31);
    chk(irqs[15:0], 16'h0001);
    ch1_event <= 1'b1;
    ch2_event <= 1'b1;
    nop(1);
    ch1_event <= 1'b0;
    ch2_event <= 1'b0;
    rd(8'he4, g);
    chk(g, 8'hf1);
    wr(8'he4, 8'hb1);
    rd(8'he4, g);
    chk(g, 8'hb1);
    for (int i = 0; i < 5; i++) begin
      dv = (ctls[i][3:2] == 2'h0) ? 1 : 8 << (2 * (ctls[i][3:2] - 1));
      wr(8'he4, ctls[i]);
      nop(130);
      u_tcz_cpu_model.op(8'he2, 8'h00, 1'b0, 1'b1, g);
      u_tcz_cpu_model.op(8'h00, 8'h00, 1'b0, 1'b0, a);
      nop(dv * 3 - 2);
      rd(8'he2, g);
      chk(8'(g - a), (i == 4) ? 8'h00 : 8'h03);
    end
    wr(8'hdb, 8'h00);
    wr(8'hda, 8'h05);
    for (int i = 0; i < 4; i++) begin
      wr(8'he5, {2'b01, acts[i], 3'b100});
      wr(8'he4, 8'h02);
      wr(8'he2, 8'h00);
      nop(9);
      chk(ch0_out, acx[i]);
      rd(8'he2, g);
      chk(g, 8'h03);
    end
    wr(8'he5, 8'h54);
    nop(3);
    o1 = ch0_out;
    cmps = 0;
    nop(6);
    chk(ch0_out, !o1);
    chk(cmps[15:0], 16'h0001);
    wr(8'he4, 8'h00);
    wr(8'he2, 8'h00);
    wr(8'hda, 8'h03);
    wr(8'he5, 8'h44);
    wr(8'he4, 8'h03);
    nop(4);
    rd(8'he2, g);
    chk(g, 8'h02);
    nop(10);
    rd(8'he4, g);
    chk(g, 8'h33);
    // Channel mask off: only the wrap mask may raise the processor flag
    wr(8'he5, 8'h04);
    ovf_irq_mask <= 1'b0;
    nop(1);
    irqs = 0;
    nop(12);
    chk(irqs[15:0], 16'h0000);
    ovf_irq_mask <= 1'b1;
    nop(7);
    chk(irqs[15:0], 16'h0001);
    wr(8'he4, 8'h00);
    wr(8'he2, 8'h00);
    for (int e = 0; e < 4; e++) begin
      for (int k = 0; k < 2; k++) begin
        wr(8'hdb, 8'h12);
        wr(8'he5, {6'b010000, e[1:0]});
        capture_pin <= (k == 0);
        nop(4);
        chk(tval[15:8], e[k] ? 8'h00 : 8'h12);
      end
    end
    wr(8'hdb, 8'h12);
    wr(8'he5, 8'hc1);
    capture_pin <= 1'b1;
    nop(4);
    chk(tval[15:8], 8'h12);
    radio_event <= 1'b1;
    nop(4);
    chk(tval[15:8], 8'h00);
    rd(8'he4, g);
    chk(g, 8'h20);
    rst <= 1'b1;
    nop(2);
    rst <= 1'b0;
    rd(8'he5, g);
    chk(g, 8'h40);
    print_verdict();
  end
endmodule : tcz_timer_tb
